// >>> src/ifeb_pkg.sv
package ifeb_pkg;

   localparam int REG_W = 16;
   localparam int EVT_W = 3;

   // register indices on the plain register port
   localparam logic [3:0] OFS_FLAG_STATUS_2 = 4'h0;
   localparam logic [3:0] OFS_FLAG_STATUS_3 = 4'h1;
   localparam logic [3:0] OFS_FLAG_STATUS_4 = 4'h2;
   localparam logic [3:0] OFS_ENABLE_CTRL_0 = 4'h3;
   localparam logic [3:0] OFS_ENABLE_CTRL_1 = 4'h4;
   localparam logic [3:0] OFS_EVT_STATUS = 4'h5;
   localparam logic [3:0] OFS_EVT_MASK = 4'h6;

   // field positions, flag register 2 (named fields in low nibble, hole at bit 13)
   localparam int BIT_CAN1_EVENT_FLAG = 3;
   localparam int BIT_CAN1_RX_READY_FLAG = 2;
   localparam int BIT_SPI_PORT2_EVENT_FLAG = 1;
   localparam int BIT_SPI_PORT2_ERROR_FLAG = 0;
   localparam int BIT_FLAG2_HOLE = 13;

   // field positions, flag register 3
   localparam int BIT_DMA_CH5_DONE_FLAG = 13;
   localparam int BIT_CAN2_EVENT_FLAG = 8;
   localparam int BIT_CAN2_RX_READY_FLAG = 7;
   localparam int BIT_EXT_IRQ4_FLAG = 6;
   localparam int BIT_EXT_IRQ3_FLAG = 5;
   localparam int BIT_TIMER9_FLAG = 4;
   localparam int BIT_TIMER8_FLAG = 3;
   localparam int BIT_I2C2_MASTER_EVENT_FLAG = 2;
   localparam int BIT_I2C2_SLAVE_EVENT_FLAG = 1;
   localparam int BIT_TIMER7_FLAG = 0;

   // field positions, flag register 4
   localparam int BIT_CAN2_TX_REQUEST_FLAG = 7;
   localparam int BIT_CAN1_TX_REQUEST_FLAG = 6;
   localparam int BIT_DMA_CH7_DONE_FLAG = 5;
   localparam int BIT_DMA_CH6_DONE_FLAG = 4;
   localparam int BIT_UART2_ERROR_FLAG = 2;
   localparam int BIT_UART1_ERROR_FLAG = 1;

   // field positions, enable registers (holes only; all others implemented)
   localparam int BIT_ENABLE0_HOLE = 15;
   localparam int BIT_ENABLE1_HOLE = 2;

   localparam logic [REG_W-1:0] MASK_FLAG_STATUS_2 =
      16'hFFFF & ~(REG_W'(1) << BIT_FLAG2_HOLE);
   localparam logic [REG_W-1:0] MASK_FLAG_STATUS_3 =
      (REG_W'(1) << BIT_DMA_CH5_DONE_FLAG) | (REG_W'(1) << BIT_CAN2_EVENT_FLAG) | 16'h00FF;
   localparam logic [REG_W-1:0] MASK_FLAG_STATUS_4 =
      (REG_W'(1) << BIT_CAN2_TX_REQUEST_FLAG) | (REG_W'(1) << BIT_CAN1_TX_REQUEST_FLAG)
      | (REG_W'(1) << BIT_DMA_CH7_DONE_FLAG) | (REG_W'(1) << BIT_DMA_CH6_DONE_FLAG)
      | (REG_W'(1) << BIT_UART2_ERROR_FLAG) | (REG_W'(1) << BIT_UART1_ERROR_FLAG);
   localparam logic [REG_W-1:0] MASK_ENABLE_CTRL_0 =
      16'hFFFF & ~(REG_W'(1) << BIT_ENABLE0_HOLE);
   localparam logic [REG_W-1:0] MASK_ENABLE_CTRL_1 =
      16'hFFFF & ~(REG_W'(1) << BIT_ENABLE1_HOLE);

   localparam logic [REG_W-1:0] RST_REG = 16'h0000;
   localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

   typedef struct packed {
      logic [3:0] addr;
      logic [REG_W-1:0] wdata;
      logic wr;
      logic rd;
   } ifeb_bus_req_type;

   typedef struct packed {
      logic [REG_W-1:0] flag_0;
      logic [REG_W-1:0] flag_1;
      logic [REG_W-1:0] enable_2;
      logic [REG_W-1:0] enable_3;
      logic [REG_W-1:0] enable_4;
   } ifeb_peer_type;

   // write replaces the stored value, an event sets its bit regardless
   function automatic logic [REG_W-1:0] ifeb_update(input logic [REG_W-1:0] cur,
                                                    input logic hit,
                                                    input logic [REG_W-1:0] wdata,
                                                    input logic [REG_W-1:0] evt,
                                                    input logic [REG_W-1:0] mask);
      logic [REG_W-1:0] base;
      base = hit ? wdata : cur;
      return (base | evt) & mask;
   endfunction : ifeb_update

endpackage : ifeb_pkg

// >>> src/ifeb_bank.sv
`timescale 1ns/1ps
// Behaviour
// - flag reads one after its source requested
// - enable set lets request through, clear blocks
// - unimplemented bits read zero, ignore writes
// - flags and enables readable and writable
// - flag reg 3: DMA5 bit 13, CAN2 bit 8
// - flag reg 3 low byte source layout
// - flag reg 4 bits 7-4 CAN/DMA flags
// - flag reg 4 bits 2,1 UART errors
// - flag reg 2 bits 2-0 CAN1 rx, SPI2
// - enable reg 0 bits 14-8 layout
// - enable reg 0 bits 7-0 layout
// - enable reg 1 bits 15-8 layout
// - enable reg 1 low byte, bit 2 absent
// - flag reg 2 bit 3 CAN1 event
module ifeb_bank import ifeb_pkg::*; #(
   parameter int ADDR_W = 4
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire ifeb_bus_req_type bus_req,
   output logic [REG_W-1:0] rdata,
   input wire logic [REG_W-1:0] src_evt_2,
   input wire logic [REG_W-1:0] src_evt_3,
   input wire logic [REG_W-1:0] src_evt_4,
   input wire ifeb_peer_type peer,
   output logic [REG_W-1:0] req_0,
   output logic [REG_W-1:0] req_1,
   output logic [REG_W-1:0] req_2,
   output logic [REG_W-1:0] req_3,
   output logic [REG_W-1:0] req_4,
   output logic irq
);

   generate
      if (ADDR_W != 4) begin : g_bad_addr_w
         $error("ifeb_bank: ADDR_W must be 4");
      end
   endgenerate

   logic [REG_W-1:0] flag_status_2;
   logic [REG_W-1:0] flag_status_3;
   logic [REG_W-1:0] flag_status_4;
   logic [REG_W-1:0] enable_ctrl_0;
   logic [REG_W-1:0] enable_ctrl_1;
   logic [EVT_W-1:0] evt_status;
   logic [EVT_W-1:0] evt_mask;

   // ---- address decode ----
   wire logic hit_f2 = bus_req.addr == OFS_FLAG_STATUS_2;
   wire logic hit_f3 = bus_req.addr == OFS_FLAG_STATUS_3;
   wire logic hit_f4 = bus_req.addr == OFS_FLAG_STATUS_4;
   wire logic hit_e0 = bus_req.addr == OFS_ENABLE_CTRL_0;
   wire logic hit_e1 = bus_req.addr == OFS_ENABLE_CTRL_1;
   wire logic hit_es = bus_req.addr == OFS_EVT_STATUS;
   wire logic hit_em = bus_req.addr == OFS_EVT_MASK;
   wire logic wr_f2 = bus_req.wr && hit_f2;
   wire logic wr_f3 = bus_req.wr && hit_f3;
   wire logic wr_f4 = bus_req.wr && hit_f4;
   wire logic wr_e0 = bus_req.wr && hit_e0;
   wire logic wr_e1 = bus_req.wr && hit_e1;
   wire logic wr_es = bus_req.wr && hit_es;
   wire logic wr_em = bus_req.wr && hit_em;

   // ---- source events, only at implemented positions ----
   wire logic [REG_W-1:0] evt_f2 = src_evt_2 & MASK_FLAG_STATUS_2;
   wire logic [REG_W-1:0] evt_f3 = src_evt_3 & MASK_FLAG_STATUS_3;
   wire logic [REG_W-1:0] evt_f4 = src_evt_4 & MASK_FLAG_STATUS_4;

   // an event in the same cycle as a clearing write still lands in the flag
   wire logic [REG_W-1:0] next_flag_status_2 =
      ifeb_update(flag_status_2, wr_f2, bus_req.wdata, evt_f2, MASK_FLAG_STATUS_2);
   wire logic [REG_W-1:0] next_flag_status_3 =
      ifeb_update(flag_status_3, wr_f3, bus_req.wdata, evt_f3, MASK_FLAG_STATUS_3);
   wire logic [REG_W-1:0] next_flag_status_4 =
      ifeb_update(flag_status_4, wr_f4, bus_req.wdata, evt_f4, MASK_FLAG_STATUS_4);
   wire logic [REG_W-1:0] next_enable_ctrl_0 =
      ifeb_update(enable_ctrl_0, wr_e0, bus_req.wdata, RST_REG, MASK_ENABLE_CTRL_0);
   wire logic [REG_W-1:0] next_enable_ctrl_1 =
      ifeb_update(enable_ctrl_1, wr_e1, bus_req.wdata, RST_REG, MASK_ENABLE_CTRL_1);

   // summary events: one bit per flag register, write one to clear, set wins
   wire logic [EVT_W-1:0] evt_new = {|evt_f4, |evt_f3, |evt_f2};
   wire logic [EVT_W-1:0] evt_clr = wr_es ? bus_req.wdata[EVT_W-1:0] : RST_EVT;
   wire logic [EVT_W-1:0] next_evt_status = (evt_status & ~evt_clr) | evt_new;
   wire logic [EVT_W-1:0] next_evt_mask = wr_em ? bus_req.wdata[EVT_W-1:0] : evt_mask;

   // ---- read mux; unmapped indices read zero ----
   wire logic [REG_W-1:0] read_mux =
      hit_f2 ? flag_status_2 :
      hit_f3 ? flag_status_3 :
      hit_f4 ? flag_status_4 :
      hit_e0 ? enable_ctrl_0 :
      hit_e1 ? enable_ctrl_1 :
      hit_es ? {{(REG_W-EVT_W){1'b0}}, evt_status} :
      hit_em ? {{(REG_W-EVT_W){1'b0}}, evt_mask} :
      RST_REG;
   wire logic [REG_W-1:0] next_rdata = bus_req.rd ? read_mux : RST_REG;

   // named enable bits, most significant first; holes never store a one
   wire logic dma_ch1_done_enable;
   wire logic adc1_done_enable;
   wire logic uart1_tx_enable_irq;
   wire logic uart1_rx_enable_irq;
   wire logic spi_port1_event_enable;
   wire logic spi_port1_error_enable;
   wire logic timer3_irq_enable;
   wire logic timer2_irq_enable;
   wire logic out_compare2_enable;
   wire logic in_capture2_enable;
   wire logic dma_ch0_done_enable;
   wire logic timer1_irq_enable;
   wire logic out_compare1_enable;
   wire logic in_capture1_enable;
   wire logic ext_irq0_enable;
   wire logic uart2_tx_enable_irq;
   wire logic uart2_rx_enable_irq;
   wire logic ext_irq2_enable;
   wire logic timer5_irq_enable;
   wire logic timer4_irq_enable;
   wire logic out_compare4_enable;
   wire logic out_compare3_enable;
   wire logic dma_ch2_done_enable;
   wire logic in_capture8_enable;
   wire logic in_capture7_enable;
   wire logic adc2_done_enable;
   wire logic ext_irq1_enable;
   wire logic change_notify_enable;
   wire logic i2c1_master_event_enable;
   wire logic i2c1_slave_event_enable;

   assign {
      dma_ch1_done_enable,
      adc1_done_enable,
      uart1_tx_enable_irq,
      uart1_rx_enable_irq,
      spi_port1_event_enable,
      spi_port1_error_enable,
      timer3_irq_enable,
      timer2_irq_enable,
      out_compare2_enable,
      in_capture2_enable,
      dma_ch0_done_enable,
      timer1_irq_enable,
      out_compare1_enable,
      in_capture1_enable,
      ext_irq0_enable
   } = enable_ctrl_0[REG_W-2:0];

   assign {
      uart2_tx_enable_irq,
      uart2_rx_enable_irq,
      ext_irq2_enable,
      timer5_irq_enable,
      timer4_irq_enable,
      out_compare4_enable,
      out_compare3_enable,
      dma_ch2_done_enable,
      in_capture8_enable,
      in_capture7_enable,
      adc2_done_enable,
      ext_irq1_enable,
      change_notify_enable
   } = enable_ctrl_1[REG_W-1:BIT_ENABLE1_HOLE+1];
   assign {i2c1_master_event_enable, i2c1_slave_event_enable} =
      enable_ctrl_1[BIT_ENABLE1_HOLE-1:0];

   wire logic [REG_W-1:0] enable_view_0 = {1'h0,
      dma_ch1_done_enable,
      adc1_done_enable,
      uart1_tx_enable_irq,
      uart1_rx_enable_irq,
      spi_port1_event_enable,
      spi_port1_error_enable,
      timer3_irq_enable,
      timer2_irq_enable,
      out_compare2_enable,
      in_capture2_enable,
      dma_ch0_done_enable,
      timer1_irq_enable,
      out_compare1_enable,
      in_capture1_enable,
      ext_irq0_enable};

   wire logic [REG_W-1:0] enable_view_1 = {
      uart2_tx_enable_irq,
      uart2_rx_enable_irq,
      ext_irq2_enable,
      timer5_irq_enable,
      timer4_irq_enable,
      out_compare4_enable,
      out_compare3_enable,
      dma_ch2_done_enable,
      in_capture8_enable,
      in_capture7_enable,
      adc2_done_enable,
      ext_irq1_enable,
      change_notify_enable,
      1'h0,
      i2c1_master_event_enable,
      i2c1_slave_event_enable};

   // named flag bits of the sparse registers; views force the holes to zero
   wire logic dma_ch5_done_flag = flag_status_3[BIT_DMA_CH5_DONE_FLAG];
   wire logic can2_event_flag = flag_status_3[BIT_CAN2_EVENT_FLAG];
   wire logic can2_rx_ready_flag = flag_status_3[BIT_CAN2_RX_READY_FLAG];
   wire logic ext_irq4_flag = flag_status_3[BIT_EXT_IRQ4_FLAG];
   wire logic ext_irq3_flag = flag_status_3[BIT_EXT_IRQ3_FLAG];
   wire logic timer9_flag = flag_status_3[BIT_TIMER9_FLAG];
   wire logic timer8_flag = flag_status_3[BIT_TIMER8_FLAG];
   wire logic i2c2_master_event_flag = flag_status_3[BIT_I2C2_MASTER_EVENT_FLAG];
   wire logic i2c2_slave_event_flag = flag_status_3[BIT_I2C2_SLAVE_EVENT_FLAG];
   wire logic timer7_flag = flag_status_3[BIT_TIMER7_FLAG];
   wire logic can2_tx_request_flag = flag_status_4[BIT_CAN2_TX_REQUEST_FLAG];
   wire logic can1_tx_request_flag = flag_status_4[BIT_CAN1_TX_REQUEST_FLAG];
   wire logic dma_ch7_done_flag = flag_status_4[BIT_DMA_CH7_DONE_FLAG];
   wire logic dma_ch6_done_flag = flag_status_4[BIT_DMA_CH6_DONE_FLAG];
   wire logic uart2_error_flag = flag_status_4[BIT_UART2_ERROR_FLAG];
   wire logic uart1_error_flag = flag_status_4[BIT_UART1_ERROR_FLAG];

   wire logic [REG_W-1:0] flag_view_3 = {2'h0, dma_ch5_done_flag, 4'h0, can2_event_flag,
      can2_rx_ready_flag,
      ext_irq4_flag,
      ext_irq3_flag,
      timer9_flag,
      timer8_flag,
      i2c2_master_event_flag,
      i2c2_slave_event_flag,
      timer7_flag};

   wire logic [REG_W-1:0] flag_view_4 = {8'h00,
      can2_tx_request_flag, can1_tx_request_flag, dma_ch7_done_flag, dma_ch6_done_flag,
      1'h0, uart2_error_flag, uart1_error_flag, 1'h0};

   // ---- request gating toward arbitration ----
   wire logic [REG_W-1:0] next_req_0 = peer.flag_0 & enable_view_0;
   wire logic [REG_W-1:0] next_req_1 = peer.flag_1 & enable_view_1;
   wire logic [REG_W-1:0] next_req_2 = flag_status_2 & peer.enable_2;
   wire logic [REG_W-1:0] next_req_3 = flag_view_3 & peer.enable_3;
   wire logic [REG_W-1:0] next_req_4 = flag_view_4 & peer.enable_4;
   wire logic next_irq = |(evt_status & evt_mask);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_status_2 <= RST_REG;
      end else begin
         flag_status_2 <= next_flag_status_2;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_status_3 <= RST_REG;
      end else begin
         flag_status_3 <= next_flag_status_3;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flag_status_4 <= RST_REG;
      end else begin
         flag_status_4 <= next_flag_status_4;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         enable_ctrl_0 <= RST_REG;
      end else begin
         enable_ctrl_0 <= next_enable_ctrl_0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         enable_ctrl_1 <= RST_REG;
      end else begin
         enable_ctrl_1 <= next_enable_ctrl_1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         evt_status <= RST_EVT;
      end else begin
         evt_status <= next_evt_status;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         evt_mask <= RST_EVT;
      end else begin
         evt_mask <= next_evt_mask;
      end
   end

   // outputs lag their cause by one cycle so each comes straight from a flop
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= RST_REG;
      end else begin
         rdata <= next_rdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_0 <= RST_REG;
      end else begin
         req_0 <= next_req_0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_1 <= RST_REG;
      end else begin
         req_1 <= next_req_1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_2 <= RST_REG;
      end else begin
         req_2 <= next_req_2;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_3 <= RST_REG;
      end else begin
         req_3 <= next_req_3;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_4 <= RST_REG;
      end else begin
         req_4 <= next_req_4;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

endmodule : ifeb_bank

// >>> testbench/ifeb_src_model.sv
`timescale 1ns/1ps
module ifeb_src_model import ifeb_pkg::*; (
   input wire logic sys_clk,
   input wire logic [1:0] sel,
   input wire logic [REG_W-1:0] pulse,
   output logic [REG_W-1:0] src_evt_2,
   output logic [REG_W-1:0] src_evt_3,
   output logic [REG_W-1:0] src_evt_4
);
   // sources pulse one cycle only, so any held flag must come from the bank
   always_ff @(posedge sys_clk) begin
      src_evt_2 <= (sel == 2'd1) ? pulse : '0;
      src_evt_3 <= (sel == 2'd2) ? pulse : '0;
      src_evt_4 <= (sel == 2'd3) ? pulse : '0;
   end
endmodule : ifeb_src_model

// >>> testbench/ifeb_bank_properties.sv
`timescale 1ns/1ps
module ifeb_bank_properties import ifeb_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire ifeb_bus_req_type bus_req,
   input wire logic [REG_W-1:0] rdata,
   input wire logic [REG_W-1:0] src_evt_2,
   input wire logic [REG_W-1:0] src_evt_3,
   input wire logic [REG_W-1:0] src_evt_4,
   input wire ifeb_peer_type peer,
   input wire logic [REG_W-1:0] req_0,
   input wire logic [REG_W-1:0] req_1,
   input wire logic [REG_W-1:0] req_2,
   input wire logic [REG_W-1:0] req_3,
   input wire logic [REG_W-1:0] req_4,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_evt3;
      (src_evt_3 != '0) ##1 1'b1;
   endsequence
   a_rd_quiet: assert property (!bus_req.rd |=> rdata == '0)
      else $error("rdata without read");
   a_unmapped_read: assert property (bus_req.rd && bus_req.addr > 4'h6 |=> rdata == '0)
      else $error("unmapped read not zero");
   a_hole_read: assert property (bus_req.rd && bus_req.addr == OFS_FLAG_STATUS_4
      |=> (rdata & ~MASK_FLAG_STATUS_4) == '0) else $error("hole bit read one");
   a_req0_gate: assert property ((req_0 & ~$past(peer.flag_0)) == '0)
      else $error("req_0 without flag");
   a_req1_gate: assert property ((req_1 & ~$past(peer.flag_1)) == '0)
      else $error("req_1 without flag");
   a_req2_gate: assert property ((req_2 & ~($past(peer.enable_2) & MASK_FLAG_STATUS_2)) == '0)
      else $error("req_2 without enable");
   a_req3_gate: assert property ((req_3 & ~($past(peer.enable_3) & MASK_FLAG_STATUS_3)) == '0)
      else $error("req_3 without enable");
   a_evt_to_req: assert property (s_evt3 |=>
      ($past(src_evt_3, 2) & $past(peer.enable_3) & MASK_FLAG_STATUS_3 & ~req_3) == '0)
      else $error("event did not reach req_3");
endmodule : ifeb_bank_properties
bind ifeb_bank ifeb_bank_properties u_ifeb_bank_properties (.sys_clk(sys_clk), .rstn(rstn),
   .bus_req(bus_req), .rdata(rdata), .src_evt_2(src_evt_2), .src_evt_3(src_evt_3),
   .src_evt_4(src_evt_4), .peer(peer), .req_0(req_0), .req_1(req_1), .req_2(req_2),
   .req_3(req_3), .req_4(req_4), .irq(irq));

// >>> testbench/ifeb_bank_tb.sv
`timescale 1ns/1ps
module ifeb_bank_tb import ifeb_pkg::*; ;
   logic sys_clk = 1'b0;
   logic rstn, irq;
   logic [1:0] sel;
   ifeb_bus_req_type bus_req;
   ifeb_peer_type peer;
   logic [REG_W-1:0] rdata, req_0, req_1, req_2, req_3, req_4, pulse, v;
   logic [REG_W-1:0] src_evt_2, src_evt_3, src_evt_4;
   logic [95:0] r;
   logic [REG_W-1:0] w [5];
   logic [REG_W-1:0] msk [5] = '{MASK_FLAG_STATUS_2, MASK_FLAG_STATUS_3, MASK_FLAG_STATUS_4,
      MASK_ENABLE_CTRL_0, MASK_ENABLE_CTRL_1};
   integer seed = 32'hA3FE79DD;
   int bad_count = 0;
   int samples_checked = 0;
   always #12.5 sys_clk = ~sys_clk;
   ifeb_bank u_ifeb_bank (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
      .src_evt_2(src_evt_2), .src_evt_3(src_evt_3), .src_evt_4(src_evt_4), .peer(peer),
      .req_0(req_0), .req_1(req_1), .req_2(req_2), .req_3(req_3), .req_4(req_4), .irq(irq));
   ifeb_src_model u_ifeb_src_model (.sys_clk(sys_clk), .sel(sel), .pulse(pulse),
      .src_evt_2(src_evt_2), .src_evt_3(src_evt_3), .src_evt_4(src_evt_4));
   task chk(input string n, input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // strobe lowered at the taking edge; the next access waits for a fresh edge
   task drv(input logic [3:0] a, input logic [REG_W-1:0] d, input logic wr, input logic rd);
      @(posedge sys_clk);
      bus_req <= {a, d, wr, rd};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
   endtask : drv
   task rdc(input logic [3:0] a, input logic [REG_W-1:0] e);
      drv(a, '0, 1'b0, 1'b1);
      chk("rdata", rdata, e);
   endtask : rdc
   task fire(input logic [1:0] s, input logic [REG_W-1:0] p);
      @(posedge sys_clk);
      sel <= s;
      pulse <= p;
      @(posedge sys_clk);
      sel <= 2'd0;
      @(posedge sys_clk);
      #1;
   endtask : fire
   task final_report;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (30000) @(posedge sys_clk);
      bad_count++;
      final_report();
   end
   initial begin
      bus_req = '0;
      peer = '0;
      sel = 2'd0;
      pulse = '0;
      rstn = 1'b0;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rdc(4'(i), '0);
      for (int i = 0; i < 5; i++) begin
         drv(4'(i), 16'hFFFF, 1'b1, 1'b0);
         rdc(4'(i), msk[i]);
         v = 16'($random(seed));
         drv(4'(i), v, 1'b1, 1'b0);
         rdc(4'(i), v & msk[i]);
      end
      drv(4'hB, 16'hFFFF, 1'b1, 1'b0);
      rdc(4'hB, '0);
      for (int i = 0; i < 3; i++) begin
         drv(4'(i), '0, 1'b1, 1'b0);
         for (int b = 0; b < 16; b++) begin
            fire(2'(i + 1), 16'h0001 << b);
            rdc(4'(i), (16'h0001 << b) & msk[i]);
            drv(4'(i), '0, 1'b1, 1'b0);
         end
      end
      repeat (20) begin
         for (int i = 0; i < 5; i++) begin
            w[i] = 16'($random(seed));
            drv(4'(i), w[i], 1'b1, 1'b0);
         end
         r = {$random(seed), $random(seed), $random(seed)};
         @(posedge sys_clk);
         peer <= r[79:0];
         @(posedge sys_clk);
         #1;
         chk("req_0", req_0, peer.flag_0 & w[3] & msk[3]);
         chk("req_1", req_1, peer.flag_1 & w[4] & msk[4]);
         chk("req_2", req_2, w[0] & msk[0] & peer.enable_2);
         chk("req_3", req_3, w[1] & msk[1] & peer.enable_3);
         chk("req_4", req_4, w[2] & msk[2] & peer.enable_4);
      end
      drv(4'h5, 16'h0007, 1'b1, 1'b0);
      drv(4'h6, 16'h0007, 1'b1, 1'b0);
      fire(2'd2, 16'h0001);
      rdc(4'h5, 16'h0002);
      chk("irq", 16'(irq), 16'h0001);
      drv(4'h6, 16'h0005, 1'b1, 1'b0);
      @(posedge sys_clk);
      #1;
      chk("irq", 16'(irq), 16'h0000);
      final_report();
   end
endmodule : ifeb_bank_tb
